// [src/acdcs_pkg.sv]
// constants shared by the clock divider and duty cycle stabilizer block
package acdcs_pkg;
    // register address and data widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    // register offsets
    localparam logic [11:0] OFS_STAB = 12'h009;
    localparam logic [11:0] OFS_DIV = 12'h00C;
    localparam logic [11:0] OFS_STATUS = 12'h00D;
    localparam logic [11:0] OFS_ALIGN = 12'h100;
    // field positions
    localparam int ALIGN_EVERY_BIT = 1;
    localparam int ALIGN_FIRST_BIT = 2;
    localparam int STAT_LOCK_BIT = 0;
    localparam int STAT_ARMED_BIT = 1;
    localparam int STAT_ACTIVE_BIT = 2;
    localparam int DIV_RATIO_MSB = 3;
    // values after reset, and the stabilizer off value
    localparam logic [7:0] STAB_RESET = 8'h01;
    localparam logic [7:0] DIV_RESET = 8'h02;
    localparam logic [7:0] ALIGN_RESET = 8'h00;
    localparam logic [7:0] STAB_OFF = 8'h00;
    // divide ratio limits
    localparam logic [3:0] RATIO_MIN = 4'h2;
    localparam logic [3:0] RATIO_MAX = 4'h8;
    // timing
    localparam int SYS_CLK_MHZ = 200;
    localparam int STAB_MIN_MHZ = 20;
    localparam int LOCK_MIN_NS = 1500;
    localparam int LOCK_MAX_NS = 5000;
    localparam int SLOW_PERIOD_INT = SYS_CLK_MHZ / STAB_MIN_MHZ;
    localparam int LOCK_CYC_INT = (LOCK_MIN_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam logic [4:0] SLOW_PERIOD_CYC = 5'(SLOW_PERIOD_INT);
    localparam logic [8:0] LOCK_CYC = 9'(LOCK_CYC_INT);
    localparam logic [4:0] SINCE_MAX = 5'h1F;
endpackage

// [src/acdcs_clk_if.sv]
// link between the clock divider and the duty cycle stabilizer
`timescale 1ns/10ps
interface acdcs_clk_if;
    logic [3:0] ratio;
    logic align;
    logic div_clk;
    logic div_rise;
    modport div (
        input ratio,
        input align,
        output div_clk,
        output div_rise
    );
    modport stab (
        input div_clk,
        input div_rise
    );
endinterface

// [src/acdcs_divider.sv]
// integer clock divider with alignment reset
`timescale 1ns/10ps
module acdcs_divider (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic smp_clk_i,
    acdcs_clk_if.div link
);
    import acdcs_pkg::*;

    logic smp_prev;
    logic [3:0] cnt;
    logic div_clk;
    logic div_rise;
    logic next_smp_prev;
    logic [3:0] next_cnt;
    logic next_div_clk;
    logic next_div_rise;
    logic rise;
    logic fall;
    logic [3:0] last;
    logic [3:0] half;

    always_comb begin
        next_smp_prev = smp_clk_i;
        next_cnt = cnt;
        next_div_clk = div_clk;
        next_div_rise = 1'b0;
        rise = smp_clk_i & ~smp_prev;
        fall = ~smp_clk_i & smp_prev;
        last = link.ratio - 4'h1;
        half = link.ratio >> 1;
        if (link.align) begin
            // back to the initial count: next input rise starts a fresh output period
            next_cnt = last;
            next_div_clk = 1'b0;
        end else begin
            if (rise) begin
                if (cnt >= last) begin
                    next_cnt = 4'h0;
                    next_div_clk = 1'b1;
                    next_div_rise = 1'b1;
                end else begin
                    next_cnt = cnt + 4'h1;
                    if (!link.ratio[0] && (cnt + 4'h1) == half) begin
                        next_div_clk = 1'b0;
                    end
                end
            end
            // odd ratio ends the high phase on an input fall, so duty follows the input
            if (fall && link.ratio[0] && cnt == half) begin
                next_div_clk = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            smp_prev <= 1'b0;
            cnt <= RATIO_MIN - 4'h1;
            div_clk <= 1'b0;
            div_rise <= 1'b0;
        end else begin
            smp_prev <= next_smp_prev;
            cnt <= next_cnt;
            div_clk <= next_div_clk;
            div_rise <= next_div_rise;
        end
    end

    assign link.div_clk = div_clk;
    assign link.div_rise = div_rise;
endmodule

// [src/acdcs_stabilizer.sv]
// duty cycle stabilizer loop with lock tracking and bypass
`timescale 1ns/10ps
module acdcs_stabilizer (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic enable_i,
    acdcs_clk_if.stab link,
    output logic stab_clk_o,
    output logic locked_o
);
    import acdcs_pkg::*;

    logic [4:0] since;
    logic [4:0] period;
    logic [8:0] lock_cnt;
    logic locked;
    logic out;
    logic [4:0] next_since;
    logic [4:0] next_period;
    logic [8:0] next_lock_cnt;
    logic next_locked;
    logic next_out;
    logic slow;

    always_comb begin
        next_since = (since == SINCE_MAX) ? since : since + 5'h1;
        next_period = period;
        next_lock_cnt = lock_cnt;
        next_locked = locked;
        slow = since > SLOW_PERIOD_CYC;
        if (link.div_rise) begin
            next_since = 5'h1;
            next_period = since;
        end
        if (!enable_i || slow) begin
            // loop cannot follow a clock this slow
            next_lock_cnt = 9'h0;
            next_locked = 1'b0;
        end else if (link.div_rise && since != period) begin
            // a new period restarts the lock wait
            next_lock_cnt = 9'h0;
            next_locked = 1'b0;
        end else if (lock_cnt >= LOCK_CYC - 9'h1) begin
            next_locked = 1'b1;
        end else begin
            next_lock_cnt = lock_cnt + 9'h1;
        end
        if (enable_i && locked) begin
            // rising edge kept, falling edge placed at half the measured period
            if (link.div_rise) begin
                next_out = 1'b1;
            end else if (since == (period >> 1)) begin
                next_out = 1'b0;
            end else begin
                next_out = out;
            end
        end else begin
            next_out = link.div_clk;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            since <= SINCE_MAX;
            period <= 5'h0;
            lock_cnt <= 9'h0;
            locked <= 1'b0;
            out <= 1'b0;
        end else begin
            since <= next_since;
            period <= next_period;
            lock_cnt <= next_lock_cnt;
            locked <= next_locked;
            out <= next_out;
        end
    end

    assign stab_clk_o = out;
    assign locked_o = locked;
endmodule

// [src/acdcs_top.sv]
// clock divider and duty cycle stabilizer control, top level with registers
//
// What this block does
// - the incoming sample clock is divided by an integer ratio from two to eight.
// - an even ratio gives a half high, half low output whatever the input duty.
// - an odd ratio of three, five or seven gives an output duty that follows the input.
// - a valid alignment pulse returns the divider to its initial count state.
// - two bits of the alignment register choose realign on every pulse or first only.
// - the enabled stabilizer rebuilds the falling edge for a balanced duty, keeping rise.
// - the stabilizer loop does not run when the clock is below twenty megahertz.
// - after a frequency change the loop needs 1.5 to 5 microseconds to relock.
// - while unlocked the loop is bypassed and timing follows the incoming duty.
// - in pin mode the stabilizer is on while the select pin is high.
// - in serial mode the stabilizer is on after reset and writing 0x00 turns it off.
// - in pin mode a low select pin leaves the stabilizer off, high being the default.
`timescale 1ns/10ps
module acdcs_top (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic smp_clk_i,
    input wire logic sync_i,
    input wire logic serial_mode_i,
    input wire logic pin_mode_stabilizer_select_i,
    input wire logic [acdcs_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [acdcs_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [acdcs_pkg::DATA_W-1:0] reg_rdata_o,
    output logic reg_rvalid_o,
    output logic internal_clk_o,
    output logic divided_clk_o,
    output logic stabilizer_active_o,
    output logic stabilizer_locked_o,
    output logic align_armed_o
);
    import acdcs_pkg::*;

    // register state
    logic [7:0] stab_reg;
    logic [7:0] div_reg;
    logic [7:0] align_reg;
    logic [7:0] next_stab_reg;
    logic [7:0] next_div_reg;
    logic [7:0] next_align_reg;

    // alignment state
    logic sync_prev;
    logic armed;
    logic next_sync_prev;
    logic next_armed;
    logic sync_pulse;
    logic align_now;

    // read port state
    logic [7:0] rdata;
    logic rvalid;
    logic [7:0] next_rdata;
    logic next_rvalid;

    // output stage state
    logic int_clk;
    logic div_clk_q;
    logic active;
    logic locked_q;
    logic next_int_clk;
    logic next_div_clk_q;
    logic next_active;
    logic next_locked_q;

    // internal wires
    logic wr_stab;
    logic wr_div;
    logic wr_align;
    logic stab_enable;
    logic [3:0] ratio;
    logic stab_clk;
    logic stab_locked;

    acdcs_clk_if link ();

    // one strobe at one register offset
    function automatic logic addr_hit(input logic strobe, input logic [11:0] a,
            input logic [11:0] ofs);
        return strobe && a == ofs;
    endfunction

    // status byte as read back at the status offset
    function automatic logic [7:0] status_byte(input logic lock, input logic arm,
            input logic en);
        logic [7:0] s;
        s = 8'h00;
        s[STAT_LOCK_BIT] = lock;
        s[STAT_ARMED_BIT] = arm;
        s[STAT_ACTIVE_BIT] = en;
        return s;
    endfunction

    // write decode
    always_comb begin
        wr_stab = addr_hit(reg_we_i, reg_addr_i, OFS_STAB);
        wr_div = addr_hit(reg_we_i, reg_addr_i, OFS_DIV);
        wr_align = addr_hit(reg_we_i, reg_addr_i, OFS_ALIGN);
    end

    // stabilizer control register
    always_comb begin
        next_stab_reg = stab_reg;
        if (wr_stab) begin
            next_stab_reg = reg_wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            stab_reg <= STAB_RESET;
        end else begin
            stab_reg <= next_stab_reg;
        end
    end

    // divide ratio register
    always_comb begin
        next_div_reg = div_reg;
        if (wr_div) begin
            next_div_reg = reg_wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            div_reg <= DIV_RESET;
        end else begin
            div_reg <= next_div_reg;
        end
    end

    // alignment control register
    always_comb begin
        next_align_reg = align_reg;
        if (wr_align) begin
            next_align_reg = reg_wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            align_reg <= ALIGN_RESET;
        end else begin
            align_reg <= next_align_reg;
        end
    end

    // ratio outside two to eight is held at the nearest limit, so the divider never stalls
    always_comb begin
        if (div_reg[DIV_RATIO_MSB:0] < RATIO_MIN) begin
            ratio = RATIO_MIN;
        end else if (div_reg[DIV_RATIO_MSB:0] > RATIO_MAX) begin
            ratio = RATIO_MAX;
        end else begin
            ratio = div_reg[DIV_RATIO_MSB:0];
        end
    end

    // stabilizer enable source
    always_comb begin
        if (serial_mode_i) begin
            stab_enable = stab_reg != STAB_OFF;
        end else begin
            // pin level used as is; the pin is assumed quiet in pin mode
            stab_enable = pin_mode_stabilizer_select_i;
        end
    end

    // alignment pin edge detector; resets low like the idle pin, so no false pulse
    always_comb begin
        next_sync_prev = sync_i;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sync_prev <= 1'b0;
        end else begin
            sync_prev <= next_sync_prev;
        end
    end

    // alignment arming
    always_comb begin
        sync_pulse = sync_i & ~sync_prev;
        align_now = 1'b0;
        next_armed = armed;
        if (sync_pulse) begin
            // first-pulse mode wins when both mode bits are set
            if (align_reg[ALIGN_FIRST_BIT]) begin
                align_now = armed;
                next_armed = 1'b0;
            end else if (align_reg[ALIGN_EVERY_BIT]) begin
                align_now = 1'b1;
            end
        end
        // a write in the same cycle as a pulse leaves the block armed again
        if (wr_align) begin
            next_armed = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            armed <= 1'b0;
        end else begin
            armed <= next_armed;
        end
    end

    assign link.ratio = ratio;
    assign link.align = align_now;

    acdcs_divider acdcs_divider_inst (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .smp_clk_i(smp_clk_i),
        .link(link)
    );

    acdcs_stabilizer acdcs_stabilizer_inst (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .enable_i(stab_enable),
        .link(link),
        .stab_clk_o(stab_clk),
        .locked_o(stab_locked)
    );

    // read port: data one cycle after the strobe, unmapped reads return zero
    always_comb begin
        next_rvalid = reg_re_i;
        next_rdata = 8'h00;
        if (reg_re_i) begin
            unique case (reg_addr_i)
                OFS_STAB: begin
                    next_rdata = stab_reg;
                end
                OFS_DIV: begin
                    next_rdata = div_reg;
                end
                OFS_ALIGN: begin
                    next_rdata = align_reg;
                end
                OFS_STATUS: begin
                    next_rdata = status_byte(stab_locked, armed, stab_enable);
                end
                default: begin
                    next_rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            rdata <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    // clock outputs; the internal clock is the stabilizer output, which bypasses when unlocked
    always_comb begin
        next_int_clk = stab_clk;
        next_div_clk_q = link.div_clk;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            int_clk <= 1'b0;
            div_clk_q <= 1'b0;
        end else begin
            int_clk <= next_int_clk;
            div_clk_q <= next_div_clk_q;
        end
    end

    // status outputs, one cycle behind the live flags
    always_comb begin
        next_active = stab_enable;
        next_locked_q = stab_locked;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            active <= 1'b0;
            locked_q <= 1'b0;
        end else begin
            active <= next_active;
            locked_q <= next_locked_q;
        end
    end

    assign reg_rdata_o = rdata;
    assign reg_rvalid_o = rvalid;
    assign internal_clk_o = int_clk;
    assign divided_clk_o = div_clk_q;
    assign stabilizer_active_o = active;
    assign stabilizer_locked_o = locked_q;
    assign align_armed_o = armed;
endmodule

// [tb/acdcs_checker.sv]
// port assertions for the clock divider and stabilizer block
`timescale 1ns/10ps
module acdcs_checker (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic smp_clk_i,
    input wire logic sync_i,
    input wire logic serial_mode_i,
    input wire logic pin_mode_stabilizer_select_i,
    input wire logic [acdcs_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [acdcs_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    input wire logic [acdcs_pkg::DATA_W-1:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    input wire logic internal_clk_o,
    input wire logic divided_clk_o,
    input wire logic stabilizer_active_o,
    input wire logic stabilizer_locked_o,
    input wire logic align_armed_o
);
    import acdcs_pkg::*;
    // divided period in system cycles and how long it has stayed the same
    logic div_q;
    logic rise;
    logic [4:0] since;
    logic [4:0] last_per;
    logic [9:0] steady;
    assign rise = divided_clk_o && !div_q;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            div_q <= 1'b0;
            since <= 5'h00;
            last_per <= 5'h00;
            steady <= 10'h000;
        end else begin
            div_q <= divided_clk_o;
            since <= rise ? 5'h01 : (since == SINCE_MAX ? since : since + 5'h01);
            last_per <= rise ? since : last_per;
            if (rise && since != last_per) begin
                steady <= 10'h000;
            end else if (steady != 10'h3FF) begin
                steady <= steady + 10'h001;
            end
        end
    end
    default clocking dck @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    AST_READ_PULSE: assert property (reg_re_i |=> reg_rvalid_o)
        else $error("read strobe not answered");
    AST_PIN_ENABLE: assert property (
        !serial_mode_i && $past(!serial_mode_i) && $past(!reset_i, 2)
        |-> stabilizer_active_o == $past(pin_mode_stabilizer_select_i))
        else $error("pin select not followed");
    AST_SERIAL_OFF: assert property (
        reg_we_i && reg_addr_i == OFS_STAB && reg_wdata_i == STAB_OFF ##1
        (serial_mode_i && !reg_we_i) [*2] |-> !stabilizer_active_o)
        else $error("stabilizer on after off write");
    AST_ARM_ON_WRITE: assert property (
        reg_we_i && reg_addr_i == OFS_ALIGN |=> align_armed_o)
        else $error("alignment not armed by write");
    AST_ARM_HOLDS_LOW: assert property (
        !align_armed_o && !reg_we_i && !$past(reg_we_i) |=> !align_armed_o)
        else $error("armed without a write");
    AST_SLOW_UNLOCK: assert property (
        rise && since > 5'h0A |-> ##[1:4] !stabilizer_locked_o)
        else $error("locked on a slow clock");
    AST_LOCK_TIME: assert property (
        $rose(stabilizer_locked_o) |-> steady >= 10'h118)
        else $error("locked too soon after a period change");
    AST_BYPASS: assert property (
        !stabilizer_locked_o [*3] |-> internal_clk_o == $past(divided_clk_o))
        else $error("unlocked output not a copy of divided clock");
endmodule

// [tb/acdcs_clk_src.sv]
// sample clock source and alignment pulse driver
`timescale 1ns/10ps
module acdcs_clk_src (
    input wire logic clk_i,
    input wire logic [7:0] period_i,
    input wire logic [7:0] high_i,
    input wire logic sync_req_i,
    output logic smp_clk_o = 1'b0,
    output logic sync_o = 1'b0
);
    logic [7:0] phase = 8'h00;
    logic [1:0] left = 2'h0;
    // free running; a new period applies from the next cycle, like a retuned source
    always @(posedge clk_i) begin
        phase <= (phase + 8'h01 >= period_i) ? 8'h00 : phase + 8'h01;
        smp_clk_o <= phase < high_i;
        left <= sync_req_i ? 2'h2 : (left == 2'h0 ? 2'h0 : left - 2'h1);
        sync_o <= sync_req_i || left > 2'h1;
    end
endmodule

// [tb/acdcs_top_test.sv]
// self-checking bench for the clock divider and stabilizer block
`timescale 1ns/10ps
module acdcs_top_test;
    import acdcs_pkg::*;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic smp_clk_i, sync_i, reg_rvalid_o, internal_clk_o, divided_clk_o;
    logic stabilizer_active_o, stabilizer_locked_o, align_armed_o;
    logic serial_mode_i = 1'b1;
    logic pin_mode_stabilizer_select_i = 1'b1;
    logic [ADDR_W-1:0] reg_addr_i = 12'h000;
    logic [DATA_W-1:0] reg_wdata_i = 8'h00;
    logic [DATA_W-1:0] reg_rdata_o;
    logic reg_we_i = 1'b0;
    logic reg_re_i = 1'b0;
    logic [7:0] period = 8'h05;
    logic [7:0] high = 8'h02;
    logic sync_req = 1'b0;
    logic dq = 1'b0;
    logic iq = 1'b0;
    int num_errors = 0;
    int n_tests = 0;
    int seed = 32'h178995AC;
    int run = 0;
    int irun = 0;
    int nr;
    int runs_q[$];
    int ihi_q[$];
    always #2.5 clk_i = ~clk_i;
    acdcs_clk_src acdcs_clk_src_inst (.clk_i(clk_i), .period_i(period), .high_i(high),
        .sync_req_i(sync_req), .smp_clk_o(smp_clk_i), .sync_o(sync_i));
    acdcs_top acdcs_top_inst (.clk_i(clk_i), .reset_i(reset_i), .smp_clk_i(smp_clk_i),
        .sync_i(sync_i), .serial_mode_i(serial_mode_i),
        .pin_mode_stabilizer_select_i(pin_mode_stabilizer_select_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
        .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
        .internal_clk_o(internal_clk_o), .divided_clk_o(divided_clk_o),
        .stabilizer_active_o(stabilizer_active_o),
        .stabilizer_locked_o(stabilizer_locked_o), .align_armed_o(align_armed_o));
    // run lengths: high runs positive, low runs negative
    always @(posedge clk_i) begin
        dq <= divided_clk_o;
        iq <= internal_clk_o;
        run <= (divided_clk_o != dq) ? 1 : run + 1;
        irun <= (internal_clk_o != iq) ? 1 : irun + 1;
        if (divided_clk_o != dq) begin
            runs_q.push_back(dq ? run : -run);
        end
        if (!internal_clk_o && iq) begin
            ihi_q.push_back(irun);
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        if (num_errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_we_i <= 1'b1;
        @(posedge clk_i);
        reg_we_i <= 1'b0;
    endtask
    task automatic reg_rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_re_i <= 1'b1;
        @(posedge clk_i);
        reg_re_i <= 1'b0;
        #1;
        check(reg_rvalid_o, 1'b1);
        check(reg_rdata_o, exp);
    endtask
    // odd ratios keep the input's high phase; even ones split the period in two
    function automatic int exp_hi(int n, int p, int h);
        return (n % 2 == 0) ? n / 2 * p : (n - 1) / 2 * p + h;
    endfunction
    task automatic ratio_run(input int r, input int p, input int h);
        int n;
        int lv;
        n = r < 2 ? 2 : (r > 8 ? 8 : r);
        reg_wr(OFS_STAB, (n % 2 == 1) ? 8'h01 : STAB_OFF);
        reg_wr(OFS_DIV, 8'(r));
        period <= 8'(p);
        high <= 8'(h);
        repeat (4 * n * p + 20) @(posedge clk_i);
        runs_q.delete();
        repeat (2 * n * p + 10) @(negedge clk_i);
        for (int i = 1; i <= 2; i++) begin
            lv = runs_q[runs_q.size() - i];
            check(lv, lv > 0 ? exp_hi(n, p, h) : exp_hi(n, p, h) - n * p);
        end
        if (n % 2 == 1) begin
            check(stabilizer_locked_o, 1'b0);
        end
    endtask
    // sync two input rises into a count, then count input rises to the next output rise
    task automatic align_try(input int exp);
        int k;
        logic sp;
        logic dp;
        @(posedge divided_clk_o);
        repeat (2) @(posedge smp_clk_i);
        @(posedge clk_i);
        sync_req <= 1'b1;
        @(posedge clk_i);
        sync_req <= 1'b0;
        @(negedge clk_i);
        k = 0;
        sp = smp_clk_i;
        dp = divided_clk_o;
        for (int c = 0; c < 800; c++) begin
            @(negedge clk_i);
            k += (smp_clk_i && !sp) ? 1 : 0;
            if (divided_clk_o && !dp) break;
            sp = smp_clk_i;
            dp = divided_clk_o;
        end
        check(k, exp);
    endtask
    task automatic wait_lock(input logic want);
        while (stabilizer_locked_o !== want && nr < 1200) begin
            @(negedge clk_i);
            nr++;
        end
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        reg_rd(OFS_STAB, STAB_RESET);
        reg_rd(OFS_DIV, DIV_RESET);
        reg_rd(OFS_ALIGN, ALIGN_RESET);
        reg_rd(12'h200 | 12'($random(seed) & 32'hFF), 8'h00);
        check(stabilizer_active_o, 1'b1);
        for (int r = 0; r < 16; r++) begin
            ratio_run(r, 5, 1 + (($random(seed) & 32'h7FFFFFFF) % 4));
        end
        // the loop ends at ratio eight, too slow to lock; ratio two stays in range
        reg_wr(OFS_DIV, 8'h02);
        reg_wr(OFS_STAB, 8'h01 | 8'($random(seed)));
        nr = 0;
        wait_lock(1'b1);
        check(stabilizer_locked_o, 1'b1);
        ihi_q.delete();
        repeat (40) @(negedge clk_i);
        check(ihi_q[$], 5);
        @(posedge clk_i);
        period <= 8'h04;
        high <= 8'h01;
        nr = 0;
        wait_lock(1'b0);
        check(stabilizer_locked_o, 1'b0);
        wait_lock(1'b1);
        check(nr >= 300 && nr <= 1000, 1'b1);
        reg_wr(OFS_STAB, STAB_OFF);
        repeat (4) @(negedge clk_i);
        check({stabilizer_active_o, stabilizer_locked_o}, 2'b00);
        @(posedge clk_i);
        serial_mode_i <= 1'b0;
        pin_mode_stabilizer_select_i <= 1'b0;
        repeat (4) @(negedge clk_i);
        check(stabilizer_active_o, 1'b0);
        @(posedge clk_i);
        pin_mode_stabilizer_select_i <= 1'b1;
        repeat (4) @(negedge clk_i);
        check(stabilizer_active_o, 1'b1);
        ratio_run(8, 8, 3);
        reg_wr(OFS_ALIGN, 8'h02);
        align_try(1);
        align_try(1);
        reg_wr(OFS_ALIGN, 8'h04);
        reg_rd(OFS_STATUS, 8'h06);
        reg_rd(OFS_ALIGN, 8'h04);
        check(align_armed_o, 1'b1);
        align_try(1);
        check(align_armed_o, 1'b0);
        align_try(6);
        reg_wr(OFS_ALIGN, 8'h04);
        align_try(1);
        stop_test();
    end
    initial begin
        #200000;
        num_errors++;
        stop_test();
    end
endmodule
bind acdcs_top acdcs_checker acdcs_checker_inst (.clk_i(clk_i), .reset_i(reset_i),
    .smp_clk_i(smp_clk_i), .sync_i(sync_i), .serial_mode_i(serial_mode_i),
    .pin_mode_stabilizer_select_i(pin_mode_stabilizer_select_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
    .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .internal_clk_o(internal_clk_o), .divided_clk_o(divided_clk_o),
    .stabilizer_active_o(stabilizer_active_o),
    .stabilizer_locked_o(stabilizer_locked_o), .align_armed_o(align_armed_o));
